// ==== hdl/mode_router_params.svh ====
`ifndef MODE_ROUTER_PARAMS_SVH
`define MODE_ROUTER_PARAMS_SVH
// Behaviour
// - One block request freezes that direction only
// - Both block requests hold output fully fixed
// - Blocking outranks safety, manual and tracking
// - Priority select 0 tracking first, 1 manual
// - Automatic only when no other request
// - Manual LED lit when manual active or preselected
// - External manual with front auto blinks 0.9
// - External manual falling edge returns to automatic
// - External LED on for tracking, safety, blocking
// - Manual first, tracking pending: external LED 0.5
// - Rhythm 0.9 is 0.1 off 0.9 on
// - Lock restricts front switching to auto or manual
// - Transmitter fault enters manual, last or safety
// - Serial write sets operator bit, front key clears
// - Remote lock 1 computer, 2 standby, 3 never
// - First internal key after serial shows warning
// - Only second key press performs the switching
// - Lock 3 inhibited by computer mode, 4 parallel
// - Computer mode is not internal and standby
// - Any message to any output, each invertible
// - Several signals on one output are ORed
// - Increment pulses on outputs 1,2,7,8, override
// - Unassigned output low, serial writable at 2
// - Tracking message needs no safety, block, or manual with priority select 1
// - Control difference offset by half scale
`define CLK_HZ          100000000
`define BLINK_PERIOD_MS 1000
`define BLINK_PERIOD_CYC (`CLK_HZ / 1000 * `BLINK_PERIOD_MS)
`define BLINK_OFF_CYC   (`BLINK_PERIOD_CYC / 10)
`define BLINK_HALF_CYC  (`BLINK_PERIOD_CYC / 2)
`define WARN_TIME_S     3
`define WARN_CYC        (`CLK_HZ * `WARN_TIME_S)
`define N_MSG           8
`define N_DO            8
`define AO_W            12
`define AO_HALF         12'h800
`define SEL_NONE        4'h0
`define FAULT_LAST_Y    2'h1
`define FAULT_SAFETY    2'h2
`define RLOCK_COMPUTER  2'h1
`define RLOCK_STANDBY   2'h2
`define MALOCK_AUTO     3'h1
`define MALOCK_MANUAL   3'h2
`define MALOCK_COMPUTER 3'h3
`define MALOCK_PARALLEL 3'h4
`define SACCESS_DO      2'h2
`define INCR_LOW_PAIR   3'h1
`define INCR_HIGH_PAIR  3'h2
`endif

// ==== hdl/mode_router_pkg.sv ====
package mode_router_pkg;
  typedef enum logic [2:0] {
    MODE_AUTO     = 3'b000,
    MODE_MANUAL   = 3'b001,
    MODE_TRACKING = 3'b010,
    MODE_SAFETY   = 3'b011,
    MODE_BLOCK    = 3'b100
  } mode_t;
endpackage

// ==== hdl/blink_gen.sv ====
`include "mode_router_params.svh"
module blink_gen (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      rhythm_09_r,
  output logic      rhythm_05_r
);
  logic [31:0] cnt_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 32'h0;
    end else if (cnt_r == 32'(`BLINK_PERIOD_CYC - 1)) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rhythm_09_r <= 1'b0;
      rhythm_05_r <= 1'b0;
    end else begin
      rhythm_09_r <= (cnt_r >= 32'(`BLINK_OFF_CYC));
      rhythm_05_r <= (cnt_r >= 32'(`BLINK_HALF_CYC));
    end
  end
endmodule // blink_gen

// ==== hdl/do_router.sv ====
`include "mode_router_params.svh"
module do_router (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [`N_MSG-1:0] msg,
  input  wire logic [`N_MSG-1:0] msg_invert,
  input  wire logic [`N_MSG*3-1:0] msg_route,
  input  wire logic [`N_MSG-1:0] msg_enable,
  input  wire logic [1:0]       incr_pulse,
  input  wire logic [2:0]       increment_route_setting,
  input  wire logic [1:0]       serial_access_setting,
  input  wire logic [`N_DO-1:0] serial_do_value,
  output logic [`N_DO-1:0]      dout_r
);
  logic [`N_DO-1:0] or_v;
  logic [`N_DO-1:0] assigned_v;
  logic [`N_DO-1:0] nxt;

  always_comb begin
    or_v       = '0;
    assigned_v = '0;
    for (int i = 0; i < `N_MSG; i++) begin
      if (msg_enable[i]) begin
        assigned_v[msg_route[i*3 +: 3]] = 1'b1;
        or_v[msg_route[i*3 +: 3]] = or_v[msg_route[i*3 +: 3]]
                                   | (msg[i] ^ msg_invert[i]);
      end
    end
    for (int d = 0; d < `N_DO; d++) begin
      if (assigned_v[d]) begin
        nxt[d] = or_v[d];
      end else if (serial_access_setting == `SACCESS_DO) begin
        nxt[d] = serial_do_value[d];
      end else begin
        nxt[d] = 1'b0;
      end
    end
    // Pulses never inverted, never ORed; only pairs 1/2 or 7/8
    case (increment_route_setting)
      `INCR_LOW_PAIR: begin
        nxt[0] = incr_pulse[0];
        nxt[1] = incr_pulse[1];
      end
      `INCR_HIGH_PAIR: begin
        nxt[6] = incr_pulse[0];
        nxt[7] = incr_pulse[1];
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_r <= '0;
    end else begin
      dout_r <= nxt;
    end
  end
endmodule // do_router

// ==== hdl/mode_router.sv ====
`include "mode_router_params.svh"
module mode_router (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [1:0]            direction_block_request,
  input  wire logic                  safety_request,
  input  wire logic                  tracking_request,
  input  wire logic                  external_manual_request,
  input  wire logic                  front_manual_key,
  input  wire logic                  front_internal_key,
  input  wire logic                  transmitter_fault_msg,
  input  wire logic                  computer_standby_signal,
  input  wire logic                  priority_select_setting,
  input  wire logic [1:0]            fault_manual_setting,
  input  wire logic [2:0]            manual_auto_lock_setting,
  input  wire logic [1:0]            remote_write_lock_setting,
  input  wire logic [1:0]            serial_access_setting,
  input  wire logic [2:0]            increment_route_setting,
  input  wire logic                  serial_internal_write,
  input  wire logic                  serial_internal_value,
  input  wire logic                  serial_manual_write,
  input  wire logic                  serial_manual_value,
  input  wire logic                  serial_status_write,
  input  wire logic [`N_DO-1:0]      serial_do_value,
  input  wire logic [`N_MSG-1:0]     msg_invert,
  input  wire logic [`N_MSG*3-1:0]   msg_route,
  input  wire logic [`N_MSG-1:0]     msg_enable,
  input  wire logic [1:0]            incr_pulse,
  input  wire logic [`N_MSG-1:0]     alarm_msgs,
  input  wire logic signed [`AO_W-1:0] control_difference,
  output logic [2:0]                 active_mode_r,
  output logic                       hold_up_r,
  output logic                       hold_down_r,
  output logic                       load_safety_r,
  output logic                       manual_led_r,
  output logic                       external_led_r,
  output logic                       tracking_active_msg_r,
  output logic                       manual_msg_r,
  output logic                       computer_mode_msg_r,
  output logic                       no_standby_msg_r,
  output logic                       internal_setpoint_r,
  output logic                       last_operator_serial_r,
  output logic                       status_write_ok_r,
  output logic                       warning_r,
  output logic [`AO_W-1:0]           analog_out_r,
  output logic [`N_DO-1:0]           digital_out_r
);
  // ******************************
  // Local state
  // ******************************
  logic       front_manual_r;
  logic       ext_manual_d_r;
  logic       front_key_d_r;
  logic       int_key_d_r;
  logic       fault_d_r;
  logic       warn_armed_r;
  logic [31:0] warn_cnt_r;
  logic       r09;
  logic       r05;
  logic       manual_cond;
  logic       block_any;
  logic       serial_locked;
  logic       int_press;
  logic       man_press;
  mode_router_pkg::mode_t mode_nxt;
  logic [`N_MSG-1:0] msgs;

  assign int_press = front_internal_key & ~int_key_d_r;
  assign man_press = front_manual_key & ~front_key_d_r;
  assign block_any = |direction_block_request;
  assign manual_cond = external_manual_request | front_manual_r;

  // Serial switching lock: computer mode in lock 3, none in 4
  assign serial_locked = (manual_auto_lock_setting == `MALOCK_COMPUTER)
                         & computer_mode_msg_r;

  blink_gen u_blink (
    .clk         (clk),
    .arst_n      (arst_n),
    .rhythm_09_r (r09),
    .rhythm_05_r (r05)
  );

  // ******************************
  // Mode priority
  // ******************************
  always_comb begin
    if (block_any) begin
      mode_nxt = mode_router_pkg::MODE_BLOCK;
    end else if (safety_request) begin
      mode_nxt = mode_router_pkg::MODE_SAFETY;
    end else if (tracking_request && (!priority_select_setting || !manual_cond)) begin
      mode_nxt = mode_router_pkg::MODE_TRACKING;
    end else if (manual_cond) begin
      mode_nxt = mode_router_pkg::MODE_MANUAL;
    end else begin
      mode_nxt = mode_router_pkg::MODE_AUTO;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_mode_r  <= 3'h0;
      hold_up_r      <= 1'b0;
      hold_down_r    <= 1'b0;
      load_safety_r  <= 1'b0;
    end else begin
      active_mode_r <= mode_nxt;
      hold_up_r     <= direction_block_request[0];
      hold_down_r   <= direction_block_request[1];
      load_safety_r <= (mode_nxt == mode_router_pkg::MODE_SAFETY)
                       | (transmitter_fault_msg & ~fault_d_r
                          & (fault_manual_setting == `FAULT_SAFETY));
    end
  end

  // ******************************
  // Front manual state
  // ******************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      front_manual_r <= 1'b0;
      ext_manual_d_r <= 1'b0;
      front_key_d_r  <= 1'b0;
      fault_d_r      <= 1'b0;
    end else begin
      ext_manual_d_r <= external_manual_request;
      front_key_d_r  <= front_manual_key;
      fault_d_r      <= transmitter_fault_msg;
      if (manual_auto_lock_setting == `MALOCK_AUTO) begin
        front_manual_r <= 1'b0;
      end else if (manual_auto_lock_setting == `MALOCK_MANUAL) begin
        front_manual_r <= 1'b1;
      end else if (transmitter_fault_msg && !fault_d_r &&
                   (fault_manual_setting == `FAULT_LAST_Y ||
                    fault_manual_setting == `FAULT_SAFETY)) begin
        front_manual_r <= 1'b1;
      end else if (serial_manual_write && !serial_locked) begin
        front_manual_r <= serial_manual_value;
      end else if (man_press) begin
        front_manual_r <= ~front_manual_r;
      end else if (!external_manual_request && ext_manual_d_r) begin
        front_manual_r <= 1'b0;
      end
    end
  end

  // ******************************
  // Internal key, warning, last operator
  // ******************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_key_d_r            <= 1'b0;
      internal_setpoint_r    <= 1'b1;
      last_operator_serial_r <= 1'b0;
      warn_armed_r           <= 1'b0;
      warn_cnt_r             <= 32'h0;
      warning_r              <= 1'b0;
    end else begin
      int_key_d_r <= front_internal_key;
      if (serial_internal_write && !serial_locked) begin
        internal_setpoint_r <= serial_internal_value;
      end else if (int_press && (!last_operator_serial_r || warn_armed_r)) begin
        internal_setpoint_r <= ~internal_setpoint_r;
      end
      // Serial write wins over a simultaneous front clear
      if ((serial_internal_write || serial_manual_write) && !serial_locked) begin
        last_operator_serial_r <= 1'b1;
      end else if (int_press || man_press) begin
        last_operator_serial_r <= 1'b0;
      end
      if (int_press && last_operator_serial_r && !warn_armed_r) begin
        warn_armed_r <= 1'b1;
      end else if (int_press) begin
        warn_armed_r <= 1'b0;
      end
      // Fresh warning restarts the full span, even mid-count
      if (int_press && last_operator_serial_r && !warn_armed_r) begin
        warn_cnt_r <= 32'(`WARN_CYC);
      end else if (warn_cnt_r != 32'h0) begin
        warn_cnt_r <= warn_cnt_r - 32'h1;
      end
      warning_r <= (warn_cnt_r > 32'h1) | (int_press & last_operator_serial_r
                   & ~warn_armed_r);
    end
  end

  // ******************************
  // Indicators and messages
  // ******************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      manual_led_r          <= 1'b0;
      external_led_r        <= 1'b0;
      tracking_active_msg_r <= 1'b0;
      manual_msg_r          <= 1'b0;
      computer_mode_msg_r   <= 1'b0;
      no_standby_msg_r      <= 1'b1;
      status_write_ok_r     <= 1'b1;
    end else begin
      if (external_manual_request && !front_manual_r) begin
        manual_led_r <= r09;
      end else begin
        manual_led_r <= manual_cond;
      end
      if (priority_select_setting && manual_cond && tracking_request
          && !block_any && !safety_request) begin
        external_led_r <= r05;
      end else begin
        external_led_r <= (mode_nxt == mode_router_pkg::MODE_TRACKING)
                          | (mode_nxt == mode_router_pkg::MODE_SAFETY)
                          | (mode_nxt == mode_router_pkg::MODE_BLOCK);
      end
      tracking_active_msg_r <= tracking_request & ~safety_request & ~block_any
                               & ~(priority_select_setting & manual_cond);
      manual_msg_r <= (mode_nxt == mode_router_pkg::MODE_MANUAL);
      computer_mode_msg_r <= ~internal_setpoint_r & computer_standby_signal;
      no_standby_msg_r <= ~(~internal_setpoint_r & computer_standby_signal);
      case (remote_write_lock_setting)
        `RLOCK_COMPUTER: status_write_ok_r <= ~computer_mode_msg_r;
        `RLOCK_STANDBY:  status_write_ok_r <= ~computer_standby_signal;
        default:         status_write_ok_r <= 1'b1;
      endcase
    end
  end

  // ******************************
  // Analog output
  // ******************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_out_r <= `AO_HALF;
    end else begin
      analog_out_r <= control_difference + `AO_HALF;
    end
  end

  // ******************************
  // Digital outputs
  // ******************************
  // Message set: 0 no standby, 1 computer, 2 manual, 3 tracking,
  // 4 transmitter fault, 5..7 alarms from outside
  assign msgs = {alarm_msgs[2:0], transmitter_fault_msg, tracking_active_msg_r,
                 manual_msg_r, computer_mode_msg_r, no_standby_msg_r};

  do_router u_do (
    .clk                     (clk),
    .arst_n                  (arst_n),
    .msg                     (msgs),
    .msg_invert              (msg_invert),
    .msg_route               (msg_route),
    .msg_enable              (msg_enable),
    .incr_pulse              (incr_pulse),
    .increment_route_setting (increment_route_setting),
    .serial_access_setting   (serial_access_setting),
    .serial_do_value         (serial_do_value),
    .dout_r                  (digital_out_r)
  );

  // ******************************
  // Checks
  // ******************************
  property p_block_first;
    @(posedge clk) disable iff (!arst_n)
      block_any |=> active_mode_r == 3'(mode_router_pkg::MODE_BLOCK);
  endproperty
  a_block_first: assert property (p_block_first) else $error("block not first");

  property p_both_hold;
    @(posedge clk) disable iff (!arst_n)
      (&direction_block_request) |=> (hold_up_r && hold_down_r);
  endproperty
  a_both_hold: assert property (p_both_hold) else $error("not fully held");

  property p_auto_only;
    @(posedge clk) disable iff (!arst_n)
      (!block_any && !safety_request && !tracking_request && !manual_cond)
      |=> active_mode_r == 3'(mode_router_pkg::MODE_AUTO);
  endproperty
  a_auto_only: assert property (p_auto_only) else $error("auto wrong");

  property p_trk_msg;
    @(posedge clk) disable iff (!arst_n)
      (tracking_request && safety_request) |=> !tracking_active_msg_r;
  endproperty
  a_trk_msg: assert property (p_trk_msg) else $error("tracking msg wrong");

  property p_cm_msg;
    @(posedge clk) disable iff (!arst_n)
      1'b1 |=> computer_mode_msg_r == ($past(~internal_setpoint_r)
                                       & $past(computer_standby_signal));
  endproperty
  a_cm_msg: assert property (p_cm_msg) else $error("computer msg wrong");

  property p_ext_fall;
    @(posedge clk) disable iff (!arst_n)
      ($fell(external_manual_request) && manual_auto_lock_setting == 3'h0
       && !man_press && !serial_manual_write && !transmitter_fault_msg)
      |=> !front_manual_r;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("no return to auto");

  property p_serial_set;
    @(posedge clk) disable iff (!arst_n)
      (serial_manual_write && !serial_locked) |=> last_operator_serial_r;
  endproperty
  a_serial_set: assert property (p_serial_set) else $error("status bit not set");

  property p_warn_no_switch;
    @(posedge clk) disable iff (!arst_n)
      (int_press && last_operator_serial_r && !warn_armed_r && !serial_internal_write)
      |=> (internal_setpoint_r == $past(internal_setpoint_r)) && warning_r;
  endproperty
  a_warn_no_switch: assert property (p_warn_no_switch) else $error("first press switched");
endmodule // mode_router

// ==== tb/control_system_model.sv ====
// ************************************************************
// Serial host and operator front keys
// ************************************************************
module control_system_model (
  input  wire logic clk,
  output logic      serial_internal_write,
  output logic      serial_internal_value,
  output logic      serial_manual_write,
  output logic      serial_manual_value,
  output logic      front_manual_key,
  output logic      front_internal_key
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    serial_internal_write = 1'b0;
    serial_internal_value = 1'b0;
    serial_manual_write   = 1'b0;
    serial_manual_value   = 1'b0;
    front_manual_key      = 1'b0;
    front_internal_key    = 1'b0;
  end

  // One-cycle write strobe; data inverted after release, never left looking valid
  task automatic serial_write(input logic to_manual, input logic value);
    @(negedge clk);
    serial_manual_write   = to_manual;
    serial_internal_write = !to_manual;
    serial_manual_value   = value;
    serial_internal_value = value;
    @(negedge clk);
    serial_manual_write   = 1'b0;
    serial_internal_write = 1'b0;
    serial_manual_value   = !value;
    serial_internal_value = !value;
  endtask

  // Key held two cycles, then two quiet cycles so edges stay distinct
  task automatic press(input logic internal_key);
    @(negedge clk);
    front_internal_key = internal_key;
    front_manual_key   = !internal_key;
    repeat (2) @(negedge clk);
    front_internal_key = 1'b0;
    front_manual_key   = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule // control_system_model

// ==== tb/controller_mode_and_output_router_test.sv ====
module controller_mode_and_output_router_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, arst_n, safety_request, tracking_request, external_manual_request, seen;
  logic transmitter_fault_msg, computer_standby_signal, priority_select_setting;
  logic serial_status_write, serial_internal_write, serial_internal_value;
  logic serial_manual_write, serial_manual_value, front_manual_key, front_internal_key;
  logic [1:0] direction_block_request, fault_manual_setting, remote_write_lock_setting;
  logic [1:0] serial_access_setting, incr_pulse;
  logic [2:0] manual_auto_lock_setting, increment_route_setting, active_mode_r, m;
  logic [7:0] serial_do_value, msg_invert, msg_enable, alarm_msgs, digital_out_r;
  logic [23:0] msg_route;
  logic signed [11:0] control_difference;
  logic [11:0] analog_out_r;
  logic hold_up_r, hold_down_r, load_safety_r, manual_led_r, external_led_r;
  logic tracking_active_msg_r, manual_msg_r, computer_mode_msg_r, no_standby_msg_r;
  logic internal_setpoint_r, last_operator_serial_r, status_write_ok_r, warning_r;
  int errors, tests_run;

  mode_router dut (.clk, .arst_n, .direction_block_request, .safety_request,
    .tracking_request, .external_manual_request, .front_manual_key, .front_internal_key,
    .transmitter_fault_msg, .computer_standby_signal, .priority_select_setting,
    .fault_manual_setting, .manual_auto_lock_setting, .remote_write_lock_setting,
    .serial_access_setting, .increment_route_setting, .serial_internal_write,
    .serial_internal_value, .serial_manual_write, .serial_manual_value, .serial_status_write,
    .serial_do_value, .msg_invert, .msg_route, .msg_enable, .incr_pulse, .alarm_msgs,
    .control_difference, .active_mode_r, .hold_up_r, .hold_down_r, .load_safety_r,
    .manual_led_r, .external_led_r, .tracking_active_msg_r, .manual_msg_r,
    .computer_mode_msg_r, .no_standby_msg_r, .internal_setpoint_r, .last_operator_serial_r,
    .status_write_ok_r, .warning_r, .analog_out_r, .digital_out_r);

  control_system_model u_host (.clk, .serial_internal_write, .serial_internal_value,
    .serial_manual_write, .serial_manual_value, .front_manual_key, .front_internal_key);

  // ************************************************************
  // Checking and expectations
  // ************************************************************
  task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Front toggle is idle here, so the manual condition is the external request
  function automatic logic [2:0] exp_mode();
    if (direction_block_request != 2'h0) return 3'h4;
    if (safety_request) return 3'h3;
    if (external_manual_request && tracking_request) return priority_select_setting ? 3'h1 : 3'h2;
    if (external_manual_request) return 3'h1;
    if (tracking_request) return 3'h2;
    return 3'h0;
  endfunction

  function automatic logic [7:0] exp_do(input logic [2:0] mm);
    logic [7:0] o;
    logic [7:0] used;
    logic [7:0] ev;
    logic [2:0] k;
    // Internal setpoint stays selected through the random phase
    ev = {alarm_msgs[2:0], transmitter_fault_msg, mm == 3'h2, mm == 3'h1, 2'b01};
    o = 8'h00;
    used = 8'h00;
    for (int i = 0; i < 8; i++) begin
      k = msg_route[i*3 +: 3];
      if (msg_enable[i]) begin
        used[k] = 1'b1;
        o[k] = o[k] | (ev[i] ^ msg_invert[i]);
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (!used[j] && serial_access_setting == 2'h2) o[j] = serial_do_value[j];
    end
    if (increment_route_setting == 3'h1) o[1:0] = incr_pulse;
    if (increment_route_setting == 3'h2) o[7:6] = incr_pulse;
    return o;
  endfunction

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    errors++;
    conclude();
  end

  initial begin
    {direction_block_request, safety_request, tracking_request, external_manual_request} = '0;
    {transmitter_fault_msg, computer_standby_signal, priority_select_setting} = '0;
    {fault_manual_setting, remote_write_lock_setting, serial_access_setting} = '0;
    {manual_auto_lock_setting, increment_route_setting, serial_status_write} = '0;
    {serial_do_value, msg_invert, msg_enable, alarm_msgs, msg_route, incr_pulse} = '0;
    control_difference = 12'h000;
    arst_n = 1'b0;
    void'($urandom(32'h0DBE3F8B));
    cyc(10);
    check("rst_internal", internal_setpoint_r, 1'b1);
    check("rst_analog", analog_out_r, 12'h800);
    check("rst_mode", active_mode_r, 3'h0);
    arst_n = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      direction_block_request = (i % 4 == 0) ? 2'($urandom) : 2'h0;
      safety_request = ($urandom % 3 == 0);
      {tracking_request, external_manual_request, priority_select_setting} = 3'($urandom);
      if (i == 0) {direction_block_request, safety_request, tracking_request} = 4'hF;
      {msg_invert, alarm_msgs, serial_do_value} = 24'($urandom);
      msg_route = 24'($urandom);
      msg_enable = 8'($urandom);
      serial_access_setting = {1'($urandom), 1'b0};
      increment_route_setting = 3'($urandom_range(0, 2));
      incr_pulse = 2'($urandom);
      control_difference = 12'($urandom);
      cyc(3);
      m = exp_mode();
      check("mode", active_mode_r, m);
      check("hold_up", hold_up_r, direction_block_request[0]);
      check("hold_down", hold_down_r, direction_block_request[1]);
      check("tracking_msg", tracking_active_msg_r, m == 3'h2);
      check("manual_msg", manual_msg_r, m == 3'h1);
      check("load_safety", load_safety_r, m == 3'h3);
      if (m >= 3'h2) check("ext_led", external_led_r, 1'b1);
      else if (!(priority_select_setting && external_manual_request && tracking_request))
        check("ext_led_off", external_led_r, 1'b0);
      if (!external_manual_request) check("manual_led", manual_led_r, 1'b0);
      check("analog", analog_out_r, 12'(12'(control_difference) + 12'h800));
      check("dout", digital_out_r, exp_do(m));
    end
    {direction_block_request, safety_request, tracking_request, external_manual_request} = '0;
    for (int s = 1; s < 3; s++) begin
      fault_manual_setting = 2'(s);
      transmitter_fault_msg = 1'b1;
      seen = 1'b0;
      repeat (3) begin
        @(negedge clk);
        seen = seen | load_safety_r;
      end
      check("fault_mode", active_mode_r, 3'h1);
      check("manual_led_on", manual_led_r, 1'b1);
      check("fault_load", seen, s == 2);
      transmitter_fault_msg = 1'b0;
      u_host.press(1'b0);
      check("front_toggle", active_mode_r, 3'h0);
    end
    manual_auto_lock_setting = 3'h2;
    cyc(3);
    check("lock_manual", active_mode_r, 3'h1);
    manual_auto_lock_setting = 3'h1;
    cyc(3);
    u_host.press(1'b0);
    check("lock_auto", active_mode_r, 3'h0);
    manual_auto_lock_setting = 3'h0;
    computer_standby_signal = 1'b1;
    u_host.serial_write(1'b0, 1'b0);
    cyc(3);
    check("internal", internal_setpoint_r, 1'b0);
    check("last_op", last_operator_serial_r, 1'b1);
    check("computer_mode", computer_mode_msg_r, 1'b1);
    check("standby_msg", no_standby_msg_r, 1'b0);
    u_host.press(1'b1);
    check("warning", warning_r, 1'b1);
    check("first_press", internal_setpoint_r, 1'b0);
    u_host.press(1'b1);
    check("second_press", internal_setpoint_r, 1'b1);
    check("last_op_clear", last_operator_serial_r, 1'b0);
    check("computer_off", computer_mode_msg_r, 1'b0);
    check("standby_off", no_standby_msg_r, 1'b1);
    u_host.serial_write(1'b0, 1'b0);
    cyc(3);
    for (int s = 0; s < 4; s++) begin
      remote_write_lock_setting = 2'(s);
      cyc(3);
      check("status_ok", status_write_ok_r, s == 0 || s == 3);
    end
    // Lock 3 must refuse while computer mode stands
    manual_auto_lock_setting = 3'h3;
    u_host.serial_write(1'b1, 1'b1);
    cyc(3);
    check("refused", active_mode_r, 3'h0);
    manual_auto_lock_setting = 3'h4;
    u_host.serial_write(1'b1, 1'b1);
    cyc(3);
    check("parallel", active_mode_r, 3'h1);
    conclude();
  end
endmodule // controller_mode_and_output_router_test
